//--- hw/lvd_params.svh
`ifndef LVD_PARAMS_SVH
`define LVD_PARAMS_SVH
// Byte offsets on the AXI4-Lite register bus
`define LVD_OFS_CTRL 12'h000
`define LVD_OFS_THRESH 12'h004
`define LVD_OFS_IRQ 12'h008
`define LVD_OFS_RSTCAUSE 12'h00c
`define LVD_OFS_INT_STAT 12'h010
`define LVD_OFS_INT_MASK 12'h014
// Control register fields
`define LVD_BIT_ENABLE 7
`define LVD_BIT_SELECT 2
`define LVD_BIT_MODE 1
`define LVD_BIT_LEVEL 0
// Request/mask register fields
`define LVD_BIT_REQ 0
`define LVD_BIT_MASK 1
// Reset-cause field
`define LVD_BIT_CAUSE 0
// Event status fields
`define LVD_EV_REQ 0
`define LVD_EV_RST 1
// Reset values
`define LVD_RST_CTRL 8'h00
`define LVD_RST_THRESH 4'h0
`define LVD_RST_INT_MASK 2'h0
// Timing
`define LVD_CLK_MHZ 200
`define LVD_STAB_US 10
`define LVD_STAB_CYC ((`LVD_STAB_US) * (`LVD_CLK_MHZ))
`endif

//--- hw/lvd_pkg.sv
`default_nettype none
package lvd_pkg;
	typedef struct packed {
		logic [11:0] addr;
		logic [31:0] data;
		logic [3:0] strb;
	} lvd_wr_s;
	typedef enum logic [1:0] {
		LVD_IDLE = 2'b00,
		LVD_RESP = 2'b01
	} lvd_bus_e;
endpackage : lvd_pkg
`default_nettype wire

//--- hw/lvd_ctrl.sv
// The implementer's own choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "lvd_params.svh"
module lvd_ctrl #(
	parameter int STAB_CYC = `LVD_STAB_CYC
) (
	// Clock and reset
	input wire logic CLK_SYS,
	input wire logic RESETN,
	// Reset cause from the system reset controller
	input wire logic SYS_RESET_BY_DETECTOR,
	// Analog comparator: high while monitored voltage is below threshold
	input wire logic COMP_BELOW,
	// Comparator controls
	output logic COMP_ENABLE,
	output logic COMP_USE_PIN,
	output logic [3:0] COMP_THRESHOLD,
	// Detector outputs
	output logic LOW_VOLTAGE_IRQ,
	output logic DETECTOR_RESET_REQ,
	output logic IRQ,
	// AXI4-Lite slave
	input wire logic [11:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [11:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY
);
	import lvd_pkg::*;

	function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
		hit = (a[11:2] == ofs[11:2]);
	endfunction : hit

	function automatic logic mapped(input logic [11:0] a);
		mapped = hit(a, `LVD_OFS_CTRL) | hit(a, `LVD_OFS_THRESH) | hit(a, `LVD_OFS_IRQ)
			| hit(a, `LVD_OFS_RSTCAUSE) | hit(a, `LVD_OFS_INT_STAT) | hit(a, `LVD_OFS_INT_MASK);
	endfunction : mapped

	// Comparator synchroniser, change accepted when stages two and three agree
	logic sync1, sync2, sync3, below;
	logic next_below;
	// Control state
	logic enable, select, mode, irq_mask, irq_req, cause, rst_req;
	logic [3:0] thresh;
	logic [1:0] int_stat, int_mask;
	logic irq_out;
	logic next_enable, next_select, next_mode, next_irq_mask, next_irq_req, next_cause, next_rst_req;
	logic [3:0] next_thresh;
	logic [1:0] next_int_stat, next_int_mask;
	logic next_irq_out;
	logic [31:0] stab_cnt, next_stab_cnt;
	logic settled;
	// Bus state
	lvd_bus_e wst, next_wst;
	lvd_bus_e rst_state, next_rst_state;
	logic aw_got, w_got, next_aw_got, next_w_got;
	lvd_wr_s wr, next_wr;
	logic [1:0] bresp, next_bresp, rresp, next_rresp;
	logic [31:0] rdata, next_rdata;
	logic do_wr;
	logic level;
	logic irq_line;
	logic [31:0] rd_mux;

	assign level = enable & below;
	assign settled = (stab_cnt == 32'h0);
	assign irq_line = enable & ~mode & level;
	assign do_wr = (wst == LVD_IDLE) & next_aw_got & next_w_got;

	always_comb begin
		next_below = below;
		if (sync2 == sync3) begin
			next_below = sync3;
		end
	end

	always_comb begin
		next_wst = wst;
		next_aw_got = aw_got;
		next_w_got = w_got;
		next_wr = wr;
		next_bresp = bresp;
		if (wst == LVD_IDLE) begin
			if (S_AXI_AWVALID & ~aw_got) begin
				next_aw_got = 1'b1;
				next_wr.addr = S_AXI_AWADDR;
			end
			if (S_AXI_WVALID & ~w_got) begin
				next_w_got = 1'b1;
				next_wr.data = S_AXI_WDATA;
				next_wr.strb = S_AXI_WSTRB;
			end
			if (next_aw_got & next_w_got) begin
				next_wst = LVD_RESP;
				next_bresp = mapped(next_wr.addr) ? 2'h0 : 2'h2;
			end
		end else if (S_AXI_BREADY) begin
			next_wst = LVD_IDLE;
			next_aw_got = 1'b0;
			next_w_got = 1'b0;
		end
	end

	always_comb begin
		rd_mux = 32'h0;
		if (hit(S_AXI_ARADDR, `LVD_OFS_CTRL)) begin
			rd_mux[`LVD_BIT_ENABLE] = enable;
			rd_mux[`LVD_BIT_SELECT] = select;
			rd_mux[`LVD_BIT_MODE] = mode;
			rd_mux[`LVD_BIT_LEVEL] = level;
		end else if (hit(S_AXI_ARADDR, `LVD_OFS_THRESH)) begin
			rd_mux[3:0] = thresh;
		end else if (hit(S_AXI_ARADDR, `LVD_OFS_IRQ)) begin
			rd_mux[`LVD_BIT_REQ] = irq_req;
			rd_mux[`LVD_BIT_MASK] = irq_mask;
			rd_mux[2] = settled;
		end else if (hit(S_AXI_ARADDR, `LVD_OFS_RSTCAUSE)) begin
			rd_mux[`LVD_BIT_CAUSE] = cause;
		end else if (hit(S_AXI_ARADDR, `LVD_OFS_INT_STAT)) begin
			rd_mux[1:0] = int_stat;
		end else if (hit(S_AXI_ARADDR, `LVD_OFS_INT_MASK)) begin
			rd_mux[1:0] = int_mask;
		end
		next_rst_state = rst_state;
		next_rdata = rdata;
		next_rresp = rresp;
		if (rst_state == LVD_IDLE) begin
			if (S_AXI_ARVALID) begin
				next_rst_state = LVD_RESP;
				next_rdata = rd_mux;
				next_rresp = mapped(S_AXI_ARADDR) ? 2'h0 : 2'h2;
			end
		end else if (S_AXI_RREADY) begin
			next_rst_state = LVD_IDLE;
		end
	end

	always_comb begin
		next_enable = enable;
		next_select = select;
		next_mode = mode;
		next_thresh = thresh;
		next_irq_mask = irq_mask;
		next_irq_req = irq_req;
		next_int_mask = int_mask;
		next_int_stat = int_stat;
		next_cause = cause;
		next_stab_cnt = stab_cnt;
		// Write lands in the cycle its last half is accepted, so use the word just captured
		if (do_wr & next_wr.strb[0]) begin
			if (hit(next_wr.addr, `LVD_OFS_CTRL)) begin
				next_enable = next_wr.data[`LVD_BIT_ENABLE];
				next_select = next_wr.data[`LVD_BIT_SELECT];
				next_mode = next_wr.data[`LVD_BIT_MODE];
				if (next_wr.data[`LVD_BIT_ENABLE] & ~enable) begin
					next_stab_cnt = STAB_CYC;
				end
			end
			if (hit(next_wr.addr, `LVD_OFS_THRESH)) begin
				next_thresh = next_wr.data[3:0];
			end
			if (hit(next_wr.addr, `LVD_OFS_IRQ)) begin
				next_irq_req = next_wr.data[`LVD_BIT_REQ];
				next_irq_mask = next_wr.data[`LVD_BIT_MASK];
			end
			if (hit(next_wr.addr, `LVD_OFS_RSTCAUSE) & next_wr.data[`LVD_BIT_CAUSE]) begin
				next_cause = 1'b0;
			end
			if (hit(next_wr.addr, `LVD_OFS_INT_STAT)) begin
				next_int_stat = int_stat & ~next_wr.data[1:0];
			end
			if (hit(next_wr.addr, `LVD_OFS_INT_MASK)) begin
				next_int_mask = next_wr.data[1:0];
			end
		end
		if (stab_cnt != 32'h0) begin
			next_stab_cnt = stab_cnt - 32'h1;
		end
		// Request flag sets on each rising edge of the request line, set beats clear
		if (irq_out == 1'b0 && irq_line == 1'b1) begin
			next_irq_req = 1'b1;
			next_int_stat[`LVD_EV_REQ] = 1'b1;
		end
		if (rst_req) begin
			next_cause = 1'b1;
			next_int_stat[`LVD_EV_RST] = 1'b1;
		end
		next_rst_req = enable & mode & level;
		next_irq_out = irq_line;
	end

	always_ff @(posedge CLK_SYS) begin
		sync1 <= COMP_BELOW;
		sync2 <= sync1;
		sync3 <= sync2;
		if (!RESETN) begin
			below <= 1'b0;
			irq_mask <= 1'b1;
			irq_req <= 1'b0;
			thresh <= `LVD_RST_THRESH;
			int_stat <= 2'h0;
			int_mask <= `LVD_RST_INT_MASK;
			rst_req <= 1'b0;
			irq_out <= 1'b0;
			stab_cnt <= 32'h0;
			wst <= LVD_IDLE;
			rst_state <= LVD_IDLE;
			aw_got <= 1'b0;
			w_got <= 1'b0;
			wr <= '0;
			bresp <= 2'h0;
			rresp <= 2'h0;
			rdata <= 32'h0;
			IRQ <= 1'b0;
			LOW_VOLTAGE_IRQ <= 1'b0;
			S_AXI_AWREADY <= 1'b1;
			S_AXI_WREADY <= 1'b1;
			S_AXI_BVALID <= 1'b0;
			S_AXI_ARREADY <= 1'b1;
			S_AXI_RVALID <= 1'b0;
		end else begin
			below <= next_below;
			irq_mask <= next_irq_mask;
			irq_req <= next_irq_req;
			thresh <= next_thresh;
			int_stat <= next_int_stat;
			int_mask <= next_int_mask;
			rst_req <= next_rst_req;
			irq_out <= next_irq_out;
			stab_cnt <= next_stab_cnt;
			wst <= next_wst;
			rst_state <= next_rst_state;
			aw_got <= next_aw_got;
			w_got <= next_w_got;
			wr <= next_wr;
			bresp <= next_bresp;
			rresp <= next_rresp;
			rdata <= next_rdata;
			IRQ <= |(next_int_stat & next_int_mask);
			LOW_VOLTAGE_IRQ <= next_irq_out & ~next_irq_mask;
			S_AXI_AWREADY <= (next_wst == LVD_IDLE) & ~next_aw_got;
			S_AXI_WREADY <= (next_wst == LVD_IDLE) & ~next_w_got;
			S_AXI_BVALID <= (next_wst == LVD_RESP);
			S_AXI_ARREADY <= (next_rst_state == LVD_IDLE);
			S_AXI_RVALID <= (next_rst_state == LVD_RESP);
		end
	end

	// Control bits and cause survive a detector-caused reset
	always_ff @(posedge CLK_SYS) begin
		if (!RESETN && !SYS_RESET_BY_DETECTOR) begin
			enable <= 1'b0;
			select <= 1'b0;
			mode <= 1'b0;
			cause <= 1'b0;
		end else if (RESETN) begin
			enable <= next_enable;
			select <= next_select;
			mode <= next_mode;
			cause <= next_cause;
		end
	end

	assign COMP_ENABLE = enable;
	assign COMP_USE_PIN = select;
	assign COMP_THRESHOLD = thresh;
	assign DETECTOR_RESET_REQ = rst_req;
	assign S_AXI_BRESP = bresp;
	assign S_AXI_RDATA = rdata;
	assign S_AXI_RRESP = rresp;
endmodule : lvd_ctrl
`default_nettype wire

//--- tb/lvd_ctrl_props.sv
`timescale 1ns/10ps
`default_nettype none
module lvd_ctrl_props (
	// Clock and reset
	input wire logic CLK_SYS,
	input wire logic RESETN,
	// Detector side
	input wire logic COMP_BELOW,
	input wire logic COMP_ENABLE,
	input wire logic LOW_VOLTAGE_IRQ,
	input wire logic DETECTOR_RESET_REQ,
	// Register bus
	input wire logic S_AXI_AWVALID,
	input wire logic S_AXI_AWREADY,
	input wire logic S_AXI_WVALID,
	input wire logic S_AXI_WREADY,
	input wire logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic S_AXI_ARVALID,
	input wire logic S_AXI_ARREADY,
	input wire logic [31:0] S_AXI_RDATA,
	input wire logic [1:0] S_AXI_RRESP,
	input wire logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY
);
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (!RESETN);
	a_rst_release: assert property ((!COMP_BELOW)[*8] |-> !DETECTOR_RESET_REQ)
		else $error("reset request while voltage good");
	a_rst_needs_enable: assert property (DETECTOR_RESET_REQ |-> $past(COMP_ENABLE))
		else $error("reset request while disabled");
	a_irq_needs_enable: assert property ((!COMP_ENABLE)[*3] |-> !LOW_VOLTAGE_IRQ)
		else $error("request while disabled");
	a_irq_needs_low: assert property ((!COMP_BELOW)[*8] |-> !LOW_VOLTAGE_IRQ)
		else $error("request while voltage good");
	a_bvalid_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
		else $error("write response dropped");
	a_rvalid_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
		else $error("read response dropped");
	a_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
		else $error("read answer late");
	a_write_answer: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |=> S_AXI_BVALID)
		else $error("write answer late");
	a_rdata_upper: assert property (S_AXI_RVALID && S_AXI_RRESP == 2'h0 |-> S_AXI_RDATA[31:8] == 24'h0)
		else $error("upper read bits set");
endmodule : lvd_ctrl_props
bind lvd_ctrl lvd_ctrl_props u_props (.CLK_SYS(CLK_SYS), .RESETN(RESETN), .COMP_BELOW(COMP_BELOW),
	.COMP_ENABLE(COMP_ENABLE), .LOW_VOLTAGE_IRQ(LOW_VOLTAGE_IRQ), .DETECTOR_RESET_REQ(DETECTOR_RESET_REQ),
	.S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID),
	.S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
	.S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA),
	.S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY));
`default_nettype wire

//--- tb/testbench.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin failures++; $display("wrong value at %0t: %h not %h", $time, a, b); end end
module testbench;
	logic clk = 0, rst_n = 0, by_det = 0, below = 0;
	logic comp_en, comp_pin, lv_irq, rst_req, irq, awready, wready, bvalid, arready, rvalid;
	logic [3:0] thr, code;
	logic [11:0] awaddr = 0, araddr = 0;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [3:0] wstrb = 4'h1;
	logic [31:0] wdata = 0, rdata;
	logic [1:0] bresp, rresp;
	logic [65:0] notes[$];
	logic [65:0] nt;
	int failures = 0, n_tests = 0;
	always #2.5 clk = ~clk;
	lvd_ctrl #(.STAB_CYC(20)) u_dut (.CLK_SYS(clk), .RESETN(rst_n), .SYS_RESET_BY_DETECTOR(by_det),
		.COMP_BELOW(below), .COMP_ENABLE(comp_en), .COMP_USE_PIN(comp_pin), .COMP_THRESHOLD(thr),
		.LOW_VOLTAGE_IRQ(lv_irq), .DETECTOR_RESET_REQ(rst_req), .IRQ(irq), .S_AXI_AWADDR(awaddr),
		.S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
		.S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
		.S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
		.S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge clk);
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		bready <= 1'b0;
		`CHK(bresp, 2'h0)
	endtask : wr
	// Read notes carry response, compare mask and expected data
	task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e, input logic [1:0] r);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		notes.push_back({r, m, e});
		do begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		rready <= 1'b0;
	endtask : rd
	always @(posedge clk) begin
		if (rvalid && rready) begin
			nt = notes.pop_front();
			`CHK(rdata & nt[63:32], nt[31:0])
			`CHK(rresp, nt[65:64])
		end
	end
	task automatic tally_and_finish();
		$display("comparisons %0d, mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : tally_and_finish
	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		tally_and_finish();
	end
	initial begin
		void'($urandom(32'h6a80));
		tick(12);
		rst_n <= 1'b1;
		rd(12'h000, 32'hff, 32'h0, 2'h0);
		rd(12'h004, 32'hff, 32'h0, 2'h0);
		rd(12'h008, 32'h3, 32'h2, 2'h0);
		rd(12'h020, 32'h0, 32'h0, 2'h2);
		wr(12'h004, 8'hff);
		rd(12'h004, 32'hff, 32'h0f, 2'h0);
		code = 4'($urandom());
		wr(12'h004, {4'h0, code});
		rd(12'h004, 32'hff, {28'h0, code}, 2'h0);
		`CHK(thr, code)
		wstrb <= 4'h2;
		wr(12'h004, {4'h0, ~code});
		wstrb <= 4'h1;
		rd(12'h004, 32'hff, {28'h0, code}, 2'h0);
		// Supply level used as reset
		wr(12'h008, 8'h02);
		wr(12'h000, 8'h80);
		tick(25);
		`CHK({comp_en, comp_pin}, 2'b10)
		rd(12'h008, 32'h4, 32'h4, 2'h0);
		rd(12'h000, 32'h1, 32'h0, 2'h0);
		wr(12'h000, 8'h82);
		tick(10);
		`CHK(rst_req, 1'b0)
		below <= 1'b1;
		tick(10);
		`CHK(rst_req, 1'b1)
		rd(12'h000, 32'h87, 32'h83, 2'h0);
		wr(12'h008, 8'h00);
		rst_n <= 1'b0;
		by_det <= 1'b1;
		below <= 1'b0;
		tick(4);
		rst_n <= 1'b1;
		by_det <= 1'b0;
		tick(10);
		`CHK(rst_req, 1'b0)
		rd(12'h000, 32'h86, 32'h82, 2'h0);
		rd(12'h00c, 32'h1, 32'h1, 2'h0);
		rd(12'h008, 32'h2, 32'h2, 2'h0);
		wr(12'h000, 8'h00);
		tick(2);
		`CHK({comp_en, rst_req}, 2'b00)
		// Pin level used as reset, stopped bit by bit
		wr(12'h000, 8'h84);
		tick(25);
		rd(12'h000, 32'h1, 32'h0, 2'h0);
		wr(12'h000, 8'h86);
		tick(10);
		`CHK({rst_req, comp_pin}, 2'b01)
		wr(12'h000, 8'h84);
		wr(12'h000, 8'h04);
		tick(2);
		`CHK(comp_en, 1'b0)
		// Supply level used as interrupt
		wr(12'h000, 8'h80);
		tick(25);
		rd(12'h000, 32'h1, 32'h0, 2'h0);
		wr(12'h008, 8'h00);
		wr(12'h000, 8'h80);
		below <= 1'b1;
		tick(10);
		`CHK({lv_irq, comp_pin}, 2'b10)
		below <= 1'b0;
		tick(10);
		`CHK(lv_irq, 1'b0)
		wr(12'h000, 8'h00);
		wr(12'h008, 8'h02);
		// Pin level used as interrupt
		wr(12'h000, 8'h84);
		tick(25);
		rd(12'h000, 32'h1, 32'h0, 2'h0);
		wr(12'h008, 8'h00);
		wr(12'h010, 8'h03);
		wr(12'h014, 8'h03);
		below <= 1'b1;
		tick(10);
		`CHK({lv_irq, irq, comp_pin}, 3'b111)
		rd(12'h008, 32'h1, 32'h1, 2'h0);
		wr(12'h014, 8'h00);
		tick(2);
		`CHK(irq, 1'b0)
		wr(12'h014, 8'h03);
		tick(2);
		`CHK(irq, 1'b1)
		wr(12'h010, 8'h03);
		tick(2);
		`CHK(irq, 1'b0)
		wr(12'h008, 8'h02);
		tick(2);
		`CHK(lv_irq, 1'b0)
		rst_n <= 1'b0;
		tick(4);
		rst_n <= 1'b1;
		rd(12'h000, 32'h86, 32'h0, 2'h0);
		tally_and_finish();
	end
endmodule : testbench
`default_nettype wire
